// File: include/mac_port_map.svh
// offsets, field positions, reset values and timing counts of the mac-side port
`ifndef MAC_PORT_MAP_SVH
`define MAC_PORT_MAP_SVH

`define REG_INT_CTRL 5'h1b
`define REG_VENDOR_CTRL 5'h1f
`define INT_EN_MSB 15
`define INT_EN_LSB 8
`define INT_COND_MSB 7
`define INT_COND_LSB 0
`define IRQ_POL_BIT 9
`define INT_EN_RESET 8'h00
`define INT_COND_RESET 8'h00
`define IRQ_POL_RESET 1'h0
`define COND_LINK_UP 0
`define COND_LINK_DOWN 2
`define ERR_NIBBLE 4'he
`define PREAMBLE_NIBBLE 4'h5
`define IDLE_DIBIT 2'h0
`define CLK_PERIOD_NS 50
`define SQE_PULSE_NS 1000
`define SQE_CYCLES 5'((`SQE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RMII_SLOW_LAST 4'h9
`define SYNC_W 19

`endif

// File: include/mac_port_pkg.sv
// types shared by the mac-side port design
package mac_port_pkg;

	typedef enum logic [2:0] {
		SYM_IDLE = 3'b000,
		SYM_JK = 3'b001,
		SYM_DATA = 3'b010,
		SYM_TR = 3'b011,
		SYM_ERR = 3'b100,
		SYM_PRE = 3'b101,
		SYM_SFD = 3'b110,
		SYM_EOF = 3'b111
	} sym_kind_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_PRE = 2'b01,
		RX_FRAME = 2'b10
	} rx_state_t;

endpackage

// File: verilog/pin_sync.sv
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = rst ? '0 : d;
		q_next = rst ? '0 : meta_reg;
	end

	always_ff @(posedge clock) begin
		meta_reg <= meta_next;
		q <= q_next;
	end
endmodule

// File: verilog/mii_rmii_mac_side_port.sv
// mac-facing mii / rmii data port with management interrupt register
`timescale 1ns/10ps
`include "mac_port_map.svh"

module mii_rmii_mac_side_port
	import mac_port_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic crystal_ref_in,
	input wire logic line_rx_clk,
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic [3:0] txd,
	input wire logic rmii_mode,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic link_up,
	input wire logic autoneg_en,
	input wire logic line_carrier,
	input wire logic [4:0] phy_addr_strap,
	input wire logic line_sym_valid,
	input wire logic [2:0] line_sym_kind,
	input wire logic [3:0] line_sym_data,
	input wire logic [7:0] status_event,
	input wire logic mgmt_req,
	input wire logic mgmt_wr,
	input wire logic [4:0] mgmt_phy,
	input wire logic [4:0] mgmt_reg,
	input wire logic [15:0] mgmt_wdata,
	output logic tx_clk_out,
	output logic rx_clk_out,
	output logic [3:0] rxd,
	output logic rx_dv,
	output logic rx_er,
	output logic crs,
	output logic col,
	output logic line_tx_valid,
	output logic [3:0] line_tx_nibble,
	output logic line_tx_halt,
	output logic mgmt_ack,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_irq_out
);
	logic [`SYNC_W-1:0] pins_s;
	logic ref_s, lrx_s, ten_s, ter_s, rmii_s, spd_s, fdx_s, lnk_s, an_s, car_s;
	logic [3:0] txd_s;
	logic [4:0] strap_s;

	pin_sync #(.W(`SYNC_W)) u_sync (
		.clock(clock),
		.rst(rst),
		.d({crystal_ref_in, line_rx_clk, tx_en, tx_er, txd, rmii_mode, speed_100,
			full_duplex, link_up, autoneg_en, line_carrier, phy_addr_strap}),
		.q(pins_s)
	);
	assign {ref_s, lrx_s, ten_s, ter_s, txd_s, rmii_s, spd_s, fdx_s, lnk_s, an_s, car_s, strap_s} = pins_s;

	// clocks and rate divider
	logic ref_prev_reg, ref_prev_next;
	logic rxclk_reg, rxclk_next;
	logic txclk_reg, txclk_next;
	logic [3:0] rate_cnt_reg, rate_cnt_next;
	logic ref_rise, rxclk_fall, rate_tick;

	always_comb begin
		ref_rise = ref_s & ~ref_prev_reg;
		rate_tick = spd_s | (rate_cnt_reg == `RMII_SLOW_LAST);
		ref_prev_next = ref_s;
		txclk_next = ref_s;
		rate_cnt_next = rate_cnt_reg;
		if (ref_rise) begin
			rate_cnt_next = rate_tick ? 4'h0 : rate_cnt_reg + 4'h1;
		end
		// recovered clock only while the line can supply it
		if (spd_s ? (lnk_s | an_s) : crs) begin
			rxclk_next = lrx_s;
		end else begin
			rxclk_next = ref_s;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ref_prev_reg <= 1'b0;
			rxclk_reg <= 1'b0;
			txclk_reg <= 1'b0;
			rate_cnt_reg <= 4'h0;
		end else begin
			ref_prev_reg <= ref_prev_next;
			rxclk_reg <= rxclk_next;
			txclk_reg <= txclk_next;
			rate_cnt_reg <= rate_cnt_next;
		end
	end
	assign rxclk_fall = rxclk_reg & ~rxclk_next;
	assign tx_clk_out = txclk_reg;
	assign rx_clk_out = rxclk_reg;

	// transmit path
	logic ten_prev_reg, ten_prev_next;
	logic tvalid_reg, tvalid_next;
	logic [3:0] tnib_reg, tnib_next;
	logic thalt_reg, thalt_next;
	logic half_reg, half_next;
	logic [1:0] lo_dibit_reg, lo_dibit_next;
	logic [4:0] sqe_reg, sqe_next;
	logic col_reg, col_next;

	always_comb begin
		ten_prev_next = ten_prev_reg;
		tvalid_next = 1'b0;
		tnib_next = tnib_reg;
		thalt_next = thalt_reg;
		half_next = half_reg;
		lo_dibit_next = lo_dibit_reg;
		sqe_next = (sqe_reg != 5'h0) ? sqe_reg - 5'h1 : 5'h0;
		if (ref_rise) begin
			ten_prev_next = ten_s;
			if (!rmii_s) begin
				if (ten_s) begin
					tvalid_next = 1'b1;
					tnib_next = txd_s;
					thalt_next = ter_s;
				end else if (ten_prev_reg && !spd_s && !fdx_s) begin
					sqe_next = `SQE_CYCLES;
				end
			end else if (rate_tick) begin
				// idle dibits outside enable are dropped, not decoded
				if (ten_s) begin
					half_next = ~half_reg;
					if (half_reg) begin
						tvalid_next = 1'b1;
						tnib_next = {txd_s[1:0], lo_dibit_reg};
						thalt_next = 1'b0;
					end else begin
						lo_dibit_next = txd_s[1:0];
					end
				end else begin
					half_next = 1'b0;
				end
			end
		end
		// level made from flops and registered, so it lags the pins by the sync delay plus one cycle
		col_next = !rmii_s && ((!fdx_s && ten_s && crs) || sqe_reg != 5'h0);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ten_prev_reg <= 1'b0;
			tvalid_reg <= 1'b0;
			tnib_reg <= 4'h0;
			thalt_reg <= 1'b0;
			half_reg <= 1'b0;
			lo_dibit_reg <= 2'h0;
			sqe_reg <= 5'h0;
			col_reg <= 1'b0;
		end else begin
			ten_prev_reg <= ten_prev_next;
			tvalid_reg <= tvalid_next;
			tnib_reg <= tnib_next;
			thalt_reg <= thalt_next;
			half_reg <= half_next;
			lo_dibit_reg <= lo_dibit_next;
			sqe_reg <= sqe_next;
			col_reg <= col_next;
		end
	end
	assign line_tx_valid = tvalid_reg;
	assign line_tx_nibble = tnib_reg;
	assign line_tx_halt = thalt_reg;
	assign col = col_reg;

	// receive path
	rx_state_t rx_state_reg, rx_state_next;
	logic pend_reg, pend_next;
	sym_kind_t pkind_reg, pkind_next;
	logic [3:0] pdata_reg, pdata_next;
	logic [3:0] rxd_reg, rxd_next;
	logic dv_reg, dv_next, er_reg, er_next, crs_reg, crs_next;
	logic [3:0] shift_reg, shift_next;
	logic [1:0] left_reg, left_next;
	logic deliver;

	always_comb begin
		rx_state_next = rx_state_reg;
		pend_next = pend_reg;
		pkind_next = pkind_reg;
		pdata_next = pdata_reg;
		rxd_next = rxd_reg;
		dv_next = dv_reg;
		er_next = er_reg;
		crs_next = crs_reg;
		shift_next = shift_reg;
		left_next = left_reg;
		deliver = 1'b0;
		if (!rmii_s && rxclk_fall) begin
			deliver = pend_reg;
			er_next = 1'b0;
			if (pend_reg) begin
				case (pkind_reg)
					SYM_JK: begin
						crs_next = 1'b1;
						dv_next = 1'b1;
						rxd_next = `PREAMBLE_NIBBLE;
						rx_state_next = RX_FRAME;
					end
					SYM_PRE: begin
						crs_next = 1'b1;
						if (rx_state_reg == RX_IDLE) begin
							rx_state_next = RX_PRE;
						end
					end
					SYM_SFD: begin
						dv_next = 1'b1;
						rxd_next = pdata_reg;
						rx_state_next = RX_FRAME;
					end
					SYM_DATA: begin
						if (rx_state_reg == RX_FRAME) begin
							rxd_next = pdata_reg;
						end
					end
					SYM_ERR: begin
						er_next = 1'b1;
						rxd_next = `ERR_NIBBLE;
					end
					SYM_TR, SYM_EOF: begin
						crs_next = 1'b0;
						dv_next = 1'b0;
						rxd_next = 4'h0;
						rx_state_next = RX_IDLE;
					end
					SYM_IDLE: begin
						if (rx_state_reg == RX_FRAME && spd_s) begin
							crs_next = 1'b0;
							dv_next = 1'b0;
							er_next = 1'b1;
							rxd_next = 4'h0;
							rx_state_next = RX_IDLE;
						end
					end
					default: begin
						rx_state_next = RX_IDLE;
					end
				endcase
			end
		end else if (rmii_s) begin
			dv_next = 1'b0;
			if (car_s) begin
				crs_next = 1'b1;
			end
			if (ref_rise && rate_tick) begin
				er_next = 1'b0;
				if (left_reg != 2'h0) begin
					rxd_next = {2'h0, shift_reg[1:0]};
					shift_next = {2'h0, shift_reg[3:2]};
					left_next = left_reg - 2'h1;
				end else if (pend_reg && pkind_reg == SYM_ERR) begin
					deliver = 1'b1;
					er_next = crs_reg;
					rxd_next = {2'h0, `IDLE_DIBIT};
				end else if (pend_reg && (pkind_reg == SYM_DATA || pkind_reg == SYM_SFD)) begin
					deliver = 1'b1;
					rxd_next = {2'h0, pdata_reg[1:0]};
					shift_next = {2'h0, pdata_reg[3:2]};
					left_next = 2'h1;
				end else begin
					deliver = pend_reg;
					rxd_next = {2'h0, `IDLE_DIBIT};
					if (!car_s) begin
						crs_next = 1'b0;
					end
				end
			end
		end
		if (deliver) begin
			pend_next = 1'b0;
		end
		// a new symbol overwrites any one not yet delivered
		if (line_sym_valid) begin
			pend_next = 1'b1;
			pkind_next = sym_kind_t'(line_sym_kind);
			pdata_next = line_sym_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rx_state_reg <= RX_IDLE;
			pend_reg <= 1'b0;
			pkind_reg <= SYM_IDLE;
			pdata_reg <= 4'h0;
			rxd_reg <= 4'h0;
			dv_reg <= 1'b0;
			er_reg <= 1'b0;
			crs_reg <= 1'b0;
			shift_reg <= 4'h0;
			left_reg <= 2'h0;
		end else begin
			rx_state_reg <= rx_state_next;
			pend_reg <= pend_next;
			pkind_reg <= pkind_next;
			pdata_reg <= pdata_next;
			rxd_reg <= rxd_next;
			dv_reg <= dv_next;
			er_reg <= er_next;
			crs_reg <= crs_next;
			shift_reg <= shift_next;
			left_reg <= left_next;
		end
	end
	assign rxd = rxd_reg;
	assign rx_dv = dv_reg;
	assign rx_er = er_reg;
	assign crs = crs_reg;

	// management registers and interrupt
	logic [1:0] strap_cnt_reg, strap_cnt_next;
	logic [4:0] addr_reg, addr_next;
	logic [7:0] en_reg, en_next, cond_reg, cond_next;
	logic pol_reg, pol_next;
	logic lnk_prev_reg, lnk_prev_next;
	logic ack_reg, ack_next;
	logic [15:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic hit;
	logic [7:0] events;

	always_comb begin
		strap_cnt_next = strap_cnt_reg;
		addr_next = addr_reg;
		// strap seen only after it has crossed the synchroniser
		if (strap_cnt_reg != 2'h3) begin
			strap_cnt_next = strap_cnt_reg + 2'h1;
			addr_next = strap_s;
		end
		hit = mgmt_req && strap_cnt_reg == 2'h3 && mgmt_phy == addr_reg;
		events = status_event;
		events[`COND_LINK_UP] = status_event[`COND_LINK_UP] | (lnk_s & ~lnk_prev_reg);
		events[`COND_LINK_DOWN] = status_event[`COND_LINK_DOWN] | (~lnk_s & lnk_prev_reg);
		lnk_prev_next = lnk_s;
		en_next = en_reg;
		pol_next = pol_reg;
		cond_next = cond_reg;
		ack_next = hit;
		rdata_next = rdata_reg;
		if (hit && mgmt_wr) begin
			if (mgmt_reg == `REG_INT_CTRL) begin
				en_next = mgmt_wdata[`INT_EN_MSB:`INT_EN_LSB];
			end else if (mgmt_reg == `REG_VENDOR_CTRL) begin
				pol_next = mgmt_wdata[`IRQ_POL_BIT];
			end
		end else if (hit) begin
			rdata_next = 16'h0000;
			if (mgmt_reg == `REG_INT_CTRL) begin
				rdata_next = {en_reg, cond_reg};
				cond_next = `INT_COND_RESET;
			end else if (mgmt_reg == `REG_VENDOR_CTRL) begin
				rdata_next[`IRQ_POL_BIT] = pol_reg;
			end
		end
		// an event in the clearing cycle survives the read
		cond_next = cond_next | events;
		irq_next = pol_next ~^ (|(cond_next & en_next));
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			strap_cnt_reg <= 2'h0;
			addr_reg <= 5'h00;
			en_reg <= `INT_EN_RESET;
			cond_reg <= `INT_COND_RESET;
			pol_reg <= `IRQ_POL_RESET;
			lnk_prev_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 16'h0000;
			irq_reg <= 1'b1;
		end else begin
			strap_cnt_reg <= strap_cnt_next;
			addr_reg <= addr_next;
			en_reg <= en_next;
			cond_reg <= cond_next;
			pol_reg <= pol_next;
			lnk_prev_reg <= lnk_prev_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
		end
	end
	assign mgmt_ack = ack_reg;
	assign mgmt_rdata = rdata_reg;
	assign mgmt_irq_out = irq_reg;
endmodule

// File: tb/port_checker.sv
// concurrent checks on the mac-side port pins
`timescale 1ns/10ps
module port_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic rmii_mode,
	input wire logic full_duplex,
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic [3:0] txd,
	input wire logic line_carrier,
	input wire logic [4:0] phy_addr_strap,
	input wire logic [7:0] status_event,
	input wire logic mgmt_req,
	input wire logic mgmt_wr,
	input wire logic [4:0] mgmt_phy,
	input wire logic [4:0] mgmt_reg,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [3:0] rxd,
	input wire logic rx_er,
	input wire logic crs,
	input wire logic col,
	input wire logic line_tx_valid,
	input wire logic [3:0] line_tx_nibble,
	input wire logic line_tx_halt,
	input wire logic mgmt_ack,
	input wire logic mgmt_irq_out
);
	logic pol_reg, pol_next, hit;
	logic [7:0] en_reg, en_next;
	// shadow of the writable control bits, so the irq level can be predicted
	always_comb begin
		hit = mgmt_req && mgmt_wr && mgmt_phy == phy_addr_strap;
		pol_next = pol_reg;
		en_next = en_reg;
		if (hit && mgmt_reg == 5'h1f) pol_next = mgmt_wdata[9];
		if (hit && mgmt_reg == 5'h1b) en_next = mgmt_wdata[15:8];
	end
	always_ff @(posedge clock) begin
		pol_reg <= rst ? 1'b0 : pol_next;
		en_reg <= rst ? 8'h00 : en_next;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_ACK_CAUSE: assert property (mgmt_ack |-> $past(mgmt_req) && $past(mgmt_phy) == phy_addr_strap)
		else $error("ack without a matching request");
	AST_NO_ACK: assert property (mgmt_req && mgmt_phy != phy_addr_strap |=> !mgmt_ack)
		else $error("ack to a foreign address");
	AST_IRQ_READ: assert property (mgmt_ack && $past(mgmt_reg) == 5'h1b && !$past(mgmt_wr)
		&& $past(status_event) == 8'h00 && status_event == 8'h00 |=> mgmt_irq_out == !pol_reg)
		else $error("irq not released by read");
	AST_IRQ_MASK: assert property (en_reg == 8'h00 && $past(en_reg) == 8'h00 && pol_reg == $past(pol_reg)
		&& pol_reg == $past(pol_reg, 2) |-> mgmt_irq_out == !pol_reg)
		else $error("irq active with all enables off");
	AST_ERR_NIBBLE: assert property (rx_er && crs && !rmii_mode && !$past(rmii_mode, 3) |-> rxd == 4'he)
		else $error("error nibble wrong");
	AST_RMII_NO_COL: assert property (rmii_mode && $past(rmii_mode, 3) |-> !col)
		else $error("collision in reduced mode");
	AST_HALT_MATCH: assert property (line_tx_valid && !rmii_mode && !$past(rmii_mode, 3)
		|-> tx_en && line_tx_halt == tx_er && line_tx_nibble == txd)
		else $error("line nibble differs from pins");
	AST_TX_SPACING: assert property (line_tx_valid |=> !line_tx_valid [*6])
		else $error("nibbles closer than a tx clock");
	AST_COL_HALF: assert property ((!full_duplex && !rmii_mode && tx_en && crs) [*4] |=> col)
		else $error("no collision");
	AST_RMII_CRS: assert property ((rmii_mode && line_carrier) [*4] |=> crs)
		else $error("carrier not shown");
	cover property (line_tx_valid && line_tx_halt);
	cover property ($rose(col));
	cover property (mgmt_ack && !mgmt_irq_out);
	cover property (line_tx_valid && rmii_mode);
endmodule

bind mii_rmii_mac_side_port port_checker i_chk (.*);

// File: tb/mac_model.sv
// behavioural mac driving the transmit pins from the reference clock
`timescale 1ns/10ps
module mac_model (
	input wire logic ref_clk,
	output logic tx_en,
	output logic tx_er,
	output logic [3:0] txd
);
	initial begin
		{tx_en, tx_er, txd} = 6'h00;
	end
	task automatic send(input logic [3:0] d, input logic er, input logic last);
		@(posedge ref_clk);
		#2;
		{tx_en, tx_er, txd} = {1'b1, er, d};
		if (last) begin
			@(posedge ref_clk);
			#2;
			// idle data is garbage on purpose, the port must ignore it
			{tx_en, tx_er, txd} = {2'b00, ~d};
		end
	endtask
	// reduced mode: low dibit first, each held reps reference periods, idle dibit 00
	task automatic send_rmii(input logic [3:0] d, input logic last, input int reps);
		repeat (reps) @(posedge ref_clk);
		#2;
		{tx_en, tx_er, txd} = {2'b10, 2'b00, d[1:0]};
		repeat (reps) @(posedge ref_clk);
		#2;
		txd = {2'b00, d[3:2]};
		if (last) begin
			repeat (reps) @(posedge ref_clk);
			#2;
			{tx_en, tx_er, txd} = 6'h00;
		end
	endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the mac-side port
`timescale 1ns/10ps
module tb_top;
	logic clock = 1'b0, rst = 1'b1, crystal_ref_in = 1'b0, line_rx_clk = 1'b0, tx_en, tx_er;
	logic rmii_mode = 1'b0, speed_100 = 1'b1, full_duplex = 1'b1, link_up = 1'b0, autoneg_en = 1'b1;
	logic line_carrier = 1'b0, line_sym_valid = 1'b0, mgmt_req = 1'b0, mgmt_wr = 1'b0, ak;
	logic tx_clk_out, rx_clk_out, rx_dv, rx_er, crs, col, line_tx_valid, line_tx_halt, mgmt_ack, mgmt_irq_out;
	logic [2:0] line_sym_kind = 3'h0;
	logic [3:0] txd, line_sym_data = 4'h0, rxd, line_tx_nibble;
	logic [4:0] phy_addr_strap = 5'h13, mgmt_phy = 5'h00, mgmt_reg = 5'h00;
	logic [7:0] status_event = 8'h00;
	logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, rd, exp_nib;
	logic [31:0] rng = 32'heed2;
	logic [4:0] exp_q[$];
	int mismatches = 0, check_count = 0, cycles = 0;
	mac_model i_mac (.ref_clk(crystal_ref_in), .tx_en(tx_en), .tx_er(tx_er), .txd(txd));
	mii_rmii_mac_side_port i_dut (.*);
	initial forever #25 clock = ~clock;
	initial begin
		#137;
		forever #200 crystal_ref_in = ~crystal_ref_in;
	end
	initial forever #190 line_rx_clk = ~line_rx_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic mgmt(input logic wr, input logic [4:0] rg, input logic [15:0] wd, input logic [4:0] phy = 5'h13);
		cyc(1);
		{mgmt_req, mgmt_wr, mgmt_phy, mgmt_reg, mgmt_wdata} = {1'b1, wr, phy, rg, wd};
		cyc(1);
		mgmt_req = 1'b0;
		ak = mgmt_ack;
		rd = mgmt_rdata;
	endtask
	task automatic pulse(input logic [7:0] ev, input logic [15:0] irq);
		status_event = ev;
		cyc(1);
		status_event = 8'h00;
		cyc(3);
		check(16'(mgmt_irq_out), irq);
	endtask
	task automatic sym_in(input logic [2:0] k, input logic [3:0] d);
		cyc(1);
		{line_sym_valid, line_sym_kind, line_sym_data} = {1'b1, k, d};
		cyc(1);
		line_sym_valid = 1'b0;
	endtask
	// a symbol shows after the next fall of the receive clock
	task automatic rx_sym(input logic [2:0] k, input logic [3:0] d, input logic [7:0] e);
		sym_in(k, d);
		wait (rx_clk_out === 1'b1);
		wait (rx_clk_out === 1'b0);
		cyc(2);
		check(16'({crs, rx_dv, rx_er, 1'b0, rxd}), 16'(e));
	endtask
	// reps 0 drives nibbles, otherwise dibits held reps reference periods
	task automatic frame(input int n, input int reps = 0);
		for (int i = 0; i < n; i++) begin
			rng = xs(rng);
			if (reps == 0) begin
				exp_q.push_back({&rng[6:4], rng[3:0]});
				i_mac.send(rng[3:0], &rng[6:4], i == n - 1);
			end else begin
				exp_q.push_back({1'b0, rng[3:0]});
				i_mac.send_rmii(rng[3:0], i == n - 1, reps);
			end
		end
		cyc(12);
	endtask
	always @(negedge clock) begin
		if (line_tx_valid === 1'b1) begin
			exp_nib = exp_q.size() ? 16'(exp_q.pop_front()) : 16'hdead;
			check(16'({line_tx_halt, line_tx_nibble}), exp_nib);
		end
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		cyc(8);
		rst = 1'b0;
		cyc(4);
		mgmt(1'b0, 5'h1b, 16'h0000);
		check(16'(ak), 16'h0001);
		check(rd, 16'h0000);
		mgmt(1'b1, 5'h1b, 16'hff5a);
		mgmt(1'b0, 5'h1b, 16'h0000);
		check(rd, 16'hff00);
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i, 16'h0000);
			mgmt(1'b0, 5'h1b, 16'h0000);
			check(rd, 16'hff00 | (16'h0001 << i));
			cyc(2);
			check(16'(mgmt_irq_out), 16'h0001);
		end
		mgmt(1'b1, 5'h1b, 16'h0100);
		pulse(8'h02, 16'h0001);
		mgmt(1'b1, 5'h1f, 16'h0200);
		mgmt(1'b0, 5'h1f, 16'h0000);
		check(rd, 16'h0200);
		pulse(8'h01, 16'h0001);
		mgmt(1'b0, 5'h1b, 16'h0000, 5'h07);
		check(16'(ak), 16'h0000);
		frame(16);
		check(16'(exp_q.size()), 16'h0000);
		@(posedge line_rx_clk);
		cyc(3);
		check(16'(rx_clk_out), 16'h0001);
		@(negedge line_rx_clk);
		cyc(3);
		check(16'(rx_clk_out), 16'h0000);
		rx_sym(3'h1, 4'h0, 8'hc5);
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			rx_sym(3'h2, rng[3:0], {4'hc, rng[3:0]});
		end
		rx_sym(3'h4, 4'h7, 8'hee);
		rx_sym(3'h2, 4'h3, 8'hc3);
		rx_sym(3'h3, 4'h0, 8'h00);
		rx_sym(3'h1, 4'h0, 8'hc5);
		rx_sym(3'h0, 4'h0, 8'h20);
		rx_sym(3'h0, 4'h0, 8'h00);
		full_duplex = 1'b0;
		rx_sym(3'h1, 4'h0, 8'hc5);
		fork
			frame(6);
		join_none
		cyc(24);
		check(16'(col), 16'h0001);
		wait fork;
		rx_sym(3'h3, 4'h0, 8'h00);
		speed_100 = 1'b0;
		frame(3);
		ak = 1'b0;
		repeat (40) begin
			cyc(1);
			ak = ak | col;
		end
		check(16'(ak), 16'h0001);
		rx_sym(3'h5, 4'h5, 8'h80);
		rx_sym(3'h6, 4'h5, 8'hc5);
		rx_sym(3'h7, 4'h0, 8'h00);
		@(posedge crystal_ref_in);
		cyc(3);
		check(16'({tx_clk_out, rx_clk_out}), 16'h0003);
		@(negedge crystal_ref_in);
		cyc(3);
		check(16'({tx_clk_out, rx_clk_out}), 16'h0000);
		{rmii_mode, speed_100, line_carrier} = 3'b111;
		cyc(6);
		check(16'({crs, rxd[1:0], col}), 16'h0008);
		sym_in(3'h2, 4'hb);
		for (int i = 0; i < 20 && rxd[1:0] === 2'h0; i++) begin
			cyc(1);
		end
		check(16'({crs, rxd[1:0]}), 16'h0007);
		cyc(8);
		check(16'({crs, rxd[1:0]}), 16'h0006);
		sym_in(3'h4, 4'h0);
		for (int i = 0; i < 20 && rx_er !== 1'b1; i++) begin
			cyc(1);
		end
		check(16'({rx_er, rxd[1:0]}), 16'h0004);
		line_carrier = 1'b0;
		cyc(24);
		check(16'({crs, rxd[1:0]}), 16'h0000);
		frame(3, 1);
		speed_100 = 1'b0;
		frame(2, 10);
		check(16'(exp_q.size()), 16'h0000);
		final_report();
	end
endmodule
